// [rtl/plfp_pkg.sv]
// constants and types for the led function and polarity block
package plfp_pkg;
  localparam int CLK_KHZ = 100_000;
  localparam int BLINK_MS = 84;
  localparam int BLINK_CYC = BLINK_MS * CLK_KHZ;
  localparam int PWM_STEP_US = 10;
  localparam int PWM_CYC = PWM_STEP_US * CLK_KHZ / 1000;
  localparam logic [5:0] IDX_FUNC = 6'h10;
  localparam logic [5:0] IDX_POLMIX = 6'h11;
  localparam logic [5:0] IDX_STATE = 6'h12;
  localparam int MIX_ODD = 12;
  localparam int MIX_EVEN = 8;
  localparam logic [15:0] FN_DEF_00 = 16'h3071;
  localparam logic [15:0] FN_DEF_01 = 16'h3771;
  localparam logic [15:0] FN_DEF_10 = 16'h7171;
  localparam logic [15:0] FN_DEF_11 = 16'h1771;
  localparam logic [3:0] MIX_DEF_LO = 4'h4;
  localparam logic [3:0] MIX_DEF_HI = 4'h8;
  localparam logic [7:0] POL_RST = 8'h00;
  localparam logic [1:0] LD_AT = 2'h2;
  typedef enum logic [3:0] {
    FC_LINK = 4'b0000,
    FC_LINK_ACT = 4'b0001,
    FC_ALT = 4'b0010,
    FC_ACT_ON = 4'b0011,
    FC_ACT_BLK = 4'b0100,
    FC_TX = 4'b0101,
    FC_FAST = 4'b0110,
    FC_100 = 4'b0111,
    FC_OFF = 4'b1000,
    FC_ON = 4'b1001,
    FC_HIZ = 4'b1010,
    FC_BLINK = 4'b1011
  } plfp_fcode_t;
  typedef enum logic [1:0] {
    SPD_10 = 2'b00,
    SPD_100 = 2'b01,
    SPD_1000 = 2'b10
  } plfp_speed_t;
  typedef struct packed {
    logic link_up;
    plfp_speed_t speed;
    logic tx_act;
    logic rx_act;
  } plfp_phy_t;
endpackage : plfp_pkg

// [rtl/plfp_top.sv]
// led function select, polarity and mixing with wishbone registers
// Functional notes
// [R1] led2 code 0 lights on link; code 1 adds blink on traffic
// [R2] led2 code 1100b and up select dual led modes for the pair
// [R3] led2 forced off, on, hi-z and blink (1011b) ignore link
// [R4] led1 code is ignored while led0 code bits 3:2 are 11b
// [R5] led1 codes 1..4 give link/traffic, link/receive, activity modes
// [R6] led1 0110b lights for 100 or 1000 link, 0111b for 100 only
// [R7] led1 codes 1000b to 1011b force off, on, hi-z or blink
// [R8] led0 code 0010b blinks three, two or one times by speed
// [R9] odd mix field at 15:12, steps of 12.5%, 1000b is 100%
// [R10] even mix field at 11:8, strap default 0100b or 1000b
// [R11] polarity field picks on/off drive levels or tristate off
// [R12] polarity fields at 7:0, kept across software reset
// [R13] led2 code 1111b drives both pair outputs as one indicator
// [R14] blinking uses one shared timer; activity from tx and rx
// [R15] mixing is a pwm ratio over a fixed eight step period
`timescale 1ns/1ps
module plfp_top
  import plfp_pkg::*;
#(
  parameter int BLINK_CYC_P = plfp_pkg::BLINK_CYC
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic SW_RST,
  input wire plfp_pkg::plfp_phy_t PHY,
  input wire logic [1:0] STRAP,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  output logic [3:0] LED_O,
  output logic [3:0] LED_OE_N
);
  import plfp_pkg::*;

  localparam int BW = $clog2(BLINK_CYC_P);
  localparam int PW = $clog2(PWM_CYC);

  // byte lane merge for 16-bit registers
  function automatic logic [15:0] merge(input logic [15:0] o,
      input logic [15:0] d, input logic [1:0] s);
    merge = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
  endfunction : merge

  // single led decode, returns {hiz, on}
  function automatic logic [1:0] fn_dec(input logic [3:0] c,
      input plfp_phy_t p, input logic blk, input logic brst,
      input logic odd);
    logic act;
    logic [1:0] r;
    act = p.tx_act | p.rx_act;
    r = 2'b00;
    case (c)
      FC_LINK: r = {1'b0, p.link_up & ~odd}; // [R1]
      FC_LINK_ACT: r = {1'b0, p.link_up & (~act | blk)}; // [R1] [R5]
      FC_ALT: r = {1'b0, odd ? p.link_up & (~p.rx_act | blk) : brst}; // [R8]
      FC_ACT_ON: r = {1'b0, act}; // [R5]
      FC_ACT_BLK: r = {1'b0, act & blk}; // [R5] [R14]
      FC_TX: r = {1'b0, p.tx_act & ~odd};
      FC_FAST: r = {1'b0, p.link_up & (p.speed != SPD_10)}; // [R6]
      FC_100: r = {1'b0, p.link_up & (p.speed == SPD_100)}; // [R6]
      FC_OFF: r = 2'b00; // [R3] [R7]
      FC_ON: r = 2'b01; // [R3] [R7]
      FC_HIZ: r = 2'b10; // [R3] [R7]
      FC_BLINK: r = {1'b0, blk}; // [R3] [R7] [R14]
      default: r = 2'b00;
    endcase
    fn_dec = r;
  endfunction : fn_dec

  // dual led pair decode
  function automatic logic dual_dec(input logic [1:0] m,
      input logic odd, input plfp_phy_t p, input logic blk);
    logic act;
    act = p.tx_act | p.rx_act;
    case (m)
      2'b00: dual_dec = p.link_up &
          (odd ? p.speed == SPD_100 : p.speed == SPD_1000);
      2'b01: dual_dec = odd ? p.link_up : act & blk;
      2'b10: dual_dec = odd ? act & blk : p.link_up;
      default: dual_dec = p.link_up & (~act | blk);
    endcase
  endfunction : dual_dec

  logic [15:0] fn_q, fn_d;
  logic [15:0] polmix_q, polmix_d;
  logic [1:0] s1_q, s2_q, strap_q;
  logic [1:0] ld_cnt_q;
  logic ack_q;
  logic [31:0] dat_q;
  logic [BW-1:0] blk_cnt_q;
  logic blink_q;
  logic [2:0] phase_q;
  logic [PW-1:0] pwm_pre_q;
  logic [2:0] pwm_q;
  logic [3:0] led_q, oe_n_q;
  logic [3:0] on_w, hiz_w, drv_w, oe_n_w;

  // bus decode
  wire req_w = CYC_I & STB_I;
  wire [5:0] idx_w = ADR_I[7:2];
  wire hit_fn = idx_w == IDX_FUNC;
  wire hit_pm = idx_w == IDX_POLMIX;
  wire hit_st = idx_w == IDX_STATE;
  wire wr_w = req_w & WE_I & ack_q;
  wire [15:0] st_w = {4'h0, 2'b00, strap_q, hiz_w, on_w};
  wire [15:0] rd_w = hit_fn ? fn_q : hit_pm ? polmix_q :
      hit_st ? st_w : 16'h0000;

  // strap defaults
  wire load_w = ld_cnt_q == LD_AT;
  wire [15:0] fn_def_w = s2_q == 2'b00 ? FN_DEF_00 :
      s2_q == 2'b01 ? FN_DEF_01 : s2_q == 2'b10 ? FN_DEF_10 : FN_DEF_11;
  wire [3:0] mix_def_w = s2_q[1] ? MIX_DEF_HI : MIX_DEF_LO; // [R10]

  assign fn_d = load_w ? fn_def_w :
      (wr_w & hit_fn) ? merge(fn_q, DAT_I[15:0], SEL_I[1:0]) : fn_q;
  // software reset has no effect on the fields
  assign polmix_d = load_w ? {mix_def_w, mix_def_w, POL_RST} :
      (wr_w & hit_pm) ? merge(polmix_q, DAT_I[15:0], SEL_I[1:0]) :
      polmix_q; // [R12]

  // shared blink timer and speed burst
  wire blk_tick = blk_cnt_q == BW'(BLINK_CYC_P - 1); // [R14]
  wire [1:0] nblk_w = ~PHY.link_up ? 2'd0 :
      PHY.speed == SPD_1000 ? 2'd3 : PHY.speed == SPD_100 ? 2'd2 : 2'd1;
  wire burst_w = (phase_q < {nblk_w, 1'b0}) & ~phase_q[0]; // [R8]
  wire pwm_tick = pwm_pre_q == PW'(PWM_CYC - 1); // [R15]

  for (genvar i = 0; i < 4; i++) begin : g_led
    localparam int PB = i & 2;
    localparam bit ODD = (i % 2) == 1;
    localparam int MX = ODD ? MIX_ODD : MIX_EVEN;
    wire [3:0] own = fn_q[4*i +: 4];
    wire [3:0] lead = fn_q[4*PB +: 4];
    wire dual = lead[3:2] == 2'b11; // [R2] [R4]
    // the combined mode lights both leds from the even mix field
    wire solo = lead[1:0] == 2'b11;
    wire [3:0] mix = polmix_q[(solo ? MIX_EVEN : MX) +: 4]; // [R9] [R13]
    wire [1:0] pol = polmix_q[2*i +: 2];
    wire [1:0] dec = fn_dec(own, PHY, blink_q, burst_w, ODD);
    wire mix_on = {1'b0, pwm_q} < mix; // [R15]
    wire dual_on = dual_dec(lead[1:0], ODD, PHY, blink_q); // [R13]
    assign on_w[i] = dual ? dual_on & mix_on : dec[0];
    assign hiz_w[i] = ~dual & dec[1];
    assign drv_w[i] = on_w[i] ? pol[0] : ~pol[0]; // [R11]
    assign oe_n_w[i] = hiz_w[i] | (~on_w[i] & pol[1]); // [R11]
  end

  assign DAT_O = dat_q;
  assign ACK_O = ack_q;
  assign LED_O = led_q;
  assign LED_OE_N = oe_n_q;

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      s1_q <= 2'b00;
      s2_q <= 2'b00;
      strap_q <= 2'b00;
      ld_cnt_q <= 2'h0;
    end else begin
      s1_q <= STRAP;
      s2_q <= s1_q;
      if (ld_cnt_q != 2'h3) begin
        ld_cnt_q <= ld_cnt_q + 2'h1;
      end
      if (load_w) begin
        strap_q <= s2_q;
      end
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      fn_q <= FN_DEF_00;
      polmix_q <= {MIX_DEF_LO, MIX_DEF_LO, POL_RST};
    end else begin
      fn_q <= fn_d;
      polmix_q <= polmix_d;
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req_w & ~ack_q;
      if (req_w & ~ack_q) begin
        dat_q <= {16'h0000, rd_w};
      end
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      blk_cnt_q <= '0;
      blink_q <= 1'b0;
      phase_q <= 3'h0;
    end else if (SW_RST) begin
      blk_cnt_q <= '0;
      blink_q <= 1'b0;
      phase_q <= 3'h0;
    end else begin
      blk_cnt_q <= blk_tick ? '0 : blk_cnt_q + 1'b1;
      if (blk_tick) begin
        blink_q <= ~blink_q;
        phase_q <= phase_q + 3'h1;
      end
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      pwm_pre_q <= '0;
      pwm_q <= 3'h0;
    end else if (SW_RST) begin
      pwm_pre_q <= '0;
      pwm_q <= 3'h0;
    end else begin
      pwm_pre_q <= pwm_tick ? '0 : pwm_pre_q + 1'b1;
      if (pwm_tick) begin
        pwm_q <= pwm_q + 3'h1;
      end
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      led_q <= 4'hF;
      oe_n_q <= 4'h0;
    end else begin
      led_q <= drv_w;
      oe_n_q <= oe_n_w;
    end
  end

  AST_LED2_LINK: assert property (@(posedge CLOCK) disable iff (RST) // [R1]
    fn_q[11:8] == FC_LINK |-> on_w[2] == PHY.link_up)
    else $error("led2 link mode wrong");

  AST_PAIR_NOLINK: assert property (@(posedge CLOCK) disable iff (RST) // [R2]
    fn_q[11:10] == 2'b11 && fn_q[9:8] != 2'b11 && !PHY.link_up
    |-> !on_w[2] && !on_w[3])
    else $error("dual mode lit without link");

  AST_LED2_BLINK: assert property (@(posedge CLOCK) disable iff (RST) // [R3]
    fn_q[11:8] == FC_BLINK |-> on_w[2] == blink_q && !hiz_w[2])
    else $error("led2 forced blink wrong");

  AST_LED1_IGNORED: assert property (@(posedge CLOCK) disable iff (RST) // [R4]
    fn_q[3:0] == 4'hC && !PHY.link_up |-> !on_w[1] && !hiz_w[1])
    else $error("led1 code not ignored");

  AST_LED1_ACT: assert property (@(posedge CLOCK) disable iff (RST) // [R5]
    fn_q[3:2] != 2'b11 && fn_q[7:4] == FC_ACT_ON
    |-> on_w[1] == (PHY.tx_act | PHY.rx_act))
    else $error("led1 activity wrong");

  AST_LED1_100: assert property (@(posedge CLOCK) disable iff (RST) // [R6]
    fn_q[3:2] != 2'b11 && fn_q[7:4] == FC_100
    |-> on_w[1] == (PHY.link_up && PHY.speed == SPD_100))
    else $error("led1 speed 100 wrong");

  AST_LED1_HIZ: assert property (@(posedge CLOCK) disable iff (RST) // [R7]
    fn_q[3:2] != 2'b11 && fn_q[7:4] == FC_HIZ |=> LED_OE_N[1])
    else $error("led1 not tristated");

  AST_POL_DRIVE: assert property (@(posedge CLOCK) disable iff (RST) // [R11]
    polmix_q[1:0] == 2'b01 && !hiz_w[0]
    |=> LED_O[0] == $past(on_w[0]) && !LED_OE_N[0])
    else $error("led0 polarity drive wrong");

  AST_SW_KEEP: assert property (@(posedge CLOCK) disable iff (RST) // [R12]
    SW_RST && !(req_w && WE_I) && !load_w |=> $stable(polmix_q))
    else $error("software reset changed fields");

  AST_COMBINED: assert property (@(posedge CLOCK) disable iff (RST) // [R13]
    fn_q[11:8] == 4'hF |-> on_w[2] == on_w[3])
    else $error("combined pair outputs differ");

  AST_BURST_NOLINK: assert property (@(posedge CLOCK) disable iff (RST) // [R8]
    fn_q[3:0] == FC_ALT && !PHY.link_up |-> !on_w[0])
    else $error("speed burst lit without link");

  AST_MIX_ZERO: assert property (@(posedge CLOCK) disable iff (RST) // [R15]
    fn_q[11:10] == 2'b11 && polmix_q[11:8] == 4'h0 |-> !on_w[2])
    else $error("zero mix still lit");

  AST_LED1_ON: assert property (@(posedge CLOCK) disable iff (RST) // [R7]
    fn_q[3:2] != 2'b11 && fn_q[7:4] == FC_ON |-> on_w[1] && !hiz_w[1])
    else $error("led1 forced on wrong");

  AST_OFF_TRI: assert property (@(posedge CLOCK) disable iff (RST) // [R11]
    !on_w[0] && polmix_q[1] |=> LED_OE_N[0])
    else $error("led0 off not tristated");

  AST_ACK_PULSE: assert property (@(posedge CLOCK) disable iff (RST)
    ACK_O |=> !ACK_O)
    else $error("ack longer than one cycle");
endmodule : plfp_top

// [test/plfp_led_model.sv]
// pin model of the indicator leds hanging on the led outputs
`timescale 1ns/1ps
module plfp_led_model (
  input wire logic [3:0] led_o,
  input wire logic [3:0] led_oe_n,
  output logic [3:0] pin,
  output logic [3:0] driven
);
  // a released pin is pulled to the supply through the led
  assign driven = ~led_oe_n;
  assign pin = (driven & led_o) | ~driven;
endmodule : plfp_led_model

// [test/tb_phy_led_function_polarity.sv]
// testbench for the led function and polarity block
`timescale 1ns/1ps
module tb_phy_led_function_polarity;
  import plfp_pkg::*;
  typedef struct packed {
    logic [15:0] fn;
    logic [15:0] pm;
    logic [4:0] phy;
    logic [3:0] pin;
    logic [3:0] drv;
  } plfp_row_t;
  logic clock, rst, sw_rst, cyc, stb, we, ack, b;
  logic [1:0] strap;
  logic [4:0] phy;
  logic [7:0] adr;
  logic [3:0] sel, led, oen, pin, drv;
  logic [31:0] dat, dat_o;
  logic [15:0] rd;
  logic [15:0] n_on, n_pair;
  int n_mismatch = 0;
  int checks = 0;
  int cycles = 0;
  plfp_row_t rows[18] = '{
    '{16'h9999, 16'h0000, 5'h14, 4'h0, 4'hF},
    '{16'h8888, 16'h0000, 5'h14, 4'hF, 4'hF},
    '{16'h9999, 16'h0055, 5'h14, 4'hF, 4'hF},
    '{16'h8888, 16'h0055, 5'h14, 4'h0, 4'hF},
    '{16'h8888, 16'h00AA, 5'h14, 4'hF, 4'h0},
    '{16'h9999, 16'h00FF, 5'h14, 4'hF, 4'hF},
    '{16'hAAAA, 16'h0055, 5'h14, 4'hF, 4'h0},
    '{16'h8060, 16'h0055, 5'h14, 4'h7, 4'hF},
    '{16'h8060, 16'h0055, 5'h10, 4'h5, 4'hF},
    '{16'h8060, 16'h0055, 5'h00, 4'h0, 4'hF},
    '{16'h8070, 16'h0055, 5'h18, 4'h5, 4'hF},
    '{16'h8188, 16'h0055, 5'h14, 4'h4, 4'hF},
    '{16'h8828, 16'h0055, 5'h14, 4'h2, 4'hF},
    '{16'h8838, 16'h0055, 5'h16, 4'h2, 4'hF},
    '{16'h8CAC, 16'h8855, 5'h18, 4'h5, 4'hF},
    '{16'h8CAC, 16'h8855, 5'h14, 4'hA, 4'hF},
    '{16'h8CAC, 16'h8855, 5'h00, 4'h0, 4'hF},
    '{16'h0F88, 16'h0855, 5'h14, 4'hC, 4'hF}};

  plfp_top #(.BLINK_CYC_P(8)) u_dut (
    .CLOCK(clock), .RST(rst), .SW_RST(sw_rst), .PHY(phy), .STRAP(strap),
    .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel),
    .DAT_I(dat), .DAT_O(dat_o), .ACK_O(ack), .LED_O(led), .LED_OE_N(oen));
  plfp_led_model u_leds (.led_o(led), .led_oe_n(oen), .pin(pin),
    .driven(drv));

  task automatic close_out;
    if (n_mismatch == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                    input logic [15:0] d);
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat <= {16'h0000, d};
    do @(posedge clock); while (ack !== 1'b1);
    rd = dat_o[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      close_out();
    end
  end

  initial begin
    rst = 1'b1;
    sw_rst = 1'b0;
    phy = 5'h00;
    strap = 2'b10;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    dat = 32'h0000_0000;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    repeat (6) @(posedge clock);
    wb(1'b0, 8'h44, 4'h3, 16'h0000);
    chk("polmix reset", rd, 16'h8800);
    wb(1'b0, 8'h40, 4'h3, 16'h0000);
    chk("fn reset", rd, 16'h7171);
    wb(1'b1, 8'h48, 4'h3, 16'hFFFF);
    wb(1'b0, 8'h48, 4'h3, 16'h0000);
    chk("status", rd, 16'h0200);
    foreach (rows[i]) begin
      phy <= rows[i].phy;
      wb(1'b1, 8'h40, 4'h3, rows[i].fn);
      wb(1'b1, 8'h44, 4'h3, rows[i].pm);
      repeat (3) @(posedge clock);
      #1;
      chk("pin", 16'(pin), 16'(rows[i].pin));
      chk("driven", 16'(drv), 16'(rows[i].drv));
    end
    // byte lane 0 only reaches the polarity fields
    wb(1'b1, 8'h44, 4'h3, 16'h8400);
    wb(1'b1, 8'h44, 4'h1, 16'hFFFF);
    wb(1'b0, 8'h44, 4'h3, 16'h0000);
    chk("lane write", rd, 16'h84FF);
    wb(1'b1, 8'h80, 4'h3, 16'hFFFF);
    wb(1'b0, 8'h80, 4'h3, 16'h0000);
    chk("unmapped", rd, 16'h0000);
    @(posedge clock);
    sw_rst <= 1'b1;
    @(posedge clock);
    sw_rst <= 1'b0;
    wb(1'b0, 8'h44, 4'h3, 16'h0000);
    chk("polmix kept", rd, 16'h84FF);
    wb(1'b1, 8'h40, 4'h3, 16'h8B88);
    wb(1'b1, 8'h44, 4'h3, 16'h0000);
    repeat (3) @(posedge clock);
    #1;
    b = pin[2];
    repeat (8) @(posedge clock);
    #1;
    chk("blink", {15'h0000, pin[2]}, {15'h0000, ~b});
    // speed burst on led0 counts lit half periods over one round
    wb(1'b1, 8'h40, 4'h3, 16'h8882);
    wb(1'b1, 8'h44, 4'h3, 16'h0055);
    for (int j = 0; j < 3; j++) begin
      phy <= j == 0 ? 5'h18 : j == 1 ? 5'h10 : 5'h00;
      n_on = 16'h0000;
      repeat (3) @(posedge clock);
      for (int k = 0; k < 8; k++) begin
        repeat (8) @(posedge clock);
        #1;
        n_on = n_on + 16'(pin[0]);
      end
      chk("burst", n_on, j == 0 ? 16'h0003 : j == 1 ? 16'h0001 : 16'h0000);
    end
    // combined pair at half mix lights half of the pwm steps
    phy <= 5'h14;
    wb(1'b1, 8'h40, 4'h3, 16'h0F88);
    wb(1'b1, 8'h44, 4'h3, 16'h0455);
    n_on = 16'h0000;
    n_pair = 16'h0000;
    for (int k = 0; k < 8; k++) begin
      repeat (PWM_CYC) @(posedge clock);
      #1;
      n_on = n_on + 16'(pin[2]);
      n_pair = n_pair + 16'(pin[3]);
    end
    chk("mix led2", n_on, 16'h0004);
    chk("mix led3", n_pair, 16'h0004);
    // second hardware reset with another strap setting
    @(posedge clock);
    rst <= 1'b1;
    strap <= 2'b01;
    repeat (3) @(posedge clock);
    #1;
    chk("reset pin", 16'(pin), 16'h000F);
    chk("reset drv", 16'(drv), 16'h000F);
    @(posedge clock);
    rst <= 1'b0;
    repeat (6) @(posedge clock);
    wb(1'b0, 8'h40, 4'h3, 16'h0000);
    chk("fn strap 01", rd, 16'h3771);
    wb(1'b0, 8'h44, 4'h3, 16'h0000);
    chk("polmix strap 01", rd, 16'h4400);
    close_out();
  end
endmodule : tb_phy_led_function_polarity
